// >>> design/sctc_consts.vh
// Constants for the step cycle travel counter: APB map, field positions,
// reset values and timing counts. Assumes a 100 MHz system clock.
`ifndef SCTC_CONSTS_VH
`define SCTC_CONSTS_VH

// Clock rates
`define SCTC_CLK_HZ          100000000
`define SCTC_TICK_HZ         2500
`define SCTC_PWR_HZ          5000
`define SCTC_PWR_DUTY_PCT    25
`define SCTC_TICK_DIV        (`SCTC_CLK_HZ / `SCTC_TICK_HZ)
`define SCTC_PWR_DIV         (`SCTC_CLK_HZ / `SCTC_PWR_HZ)
`define SCTC_PWR_ON          ((`SCTC_PWR_DIV * `SCTC_PWR_DUTY_PCT) / 100)

// Interval times in milliseconds and their counts of 2.5 kc ticks
`define SCTC_LOCKOUT_MS      250
`define SCTC_WARMUP_MS       30
`define SCTC_MOTOR_MS        40
`define SCTC_LOCKOUT_TICKS   ((`SCTC_LOCKOUT_MS * `SCTC_TICK_HZ) / 1000)
`define SCTC_WARMUP_TICKS    ((`SCTC_WARMUP_MS * `SCTC_TICK_HZ) / 1000)
`define SCTC_MOTOR_TICKS     ((`SCTC_MOTOR_MS * `SCTC_TICK_HZ) / 1000)

// Counting chain
`define SCTC_DECADE_LAST     4'd9
`define SCTC_RING5_HOME      5'h01
`define SCTC_RING4_HOME      4'h1

// Cycle states
`define SCTC_ST_IDLE         2'd0
`define SCTC_ST_WARM         2'd1
`define SCTC_ST_COMP         2'd2

// APB register byte offsets
`define SCTC_ADDR_CTRL       12'h000
`define SCTC_ADDR_STATUS     12'h004
`define SCTC_ADDR_RINGS      12'h008
`define SCTC_ADDR_STEPS      12'h00c

// Control register fields and reset value
`define SCTC_CTRL_EN_BIT     0
`define SCTC_CTRL_CLR_BIT    1
`define SCTC_CTRL_RESET      1'b1

`endif

// >>> design/sctc_top.v
// Step cycle control and two-channel travel accumulation with stepper drive.
// Assumes non-APB pin inputs are asynchronous to MCLK; two flops synchronise them here, one for CAL_MODE and FAST_SLEW;
// ramp, comparators, compass sensors and motor power stages sit outside.

`timescale 1ns/1ns
`include "sctc_consts.vh"

module sctc_top #(
    parameter TICK_DIV = `SCTC_TICK_DIV,         // MCLK cycles per 2.5 kc tick
    parameter PWR_DIV  = `SCTC_PWR_DIV,          // MCLK cycles per decade supply period
    parameter PWR_ON   = `SCTC_PWR_ON            // MCLK cycles of supply on-time
) (
    input  wire        MCLK,                     // system clock, 100 MHz
    input  wire        RESETN,                   // asynchronous reset, active low
    input  wire        PSEL,                     // APB select
    input  wire        PENABLE,                  // APB access phase
    input  wire        PWRITE,                   // APB write
    input  wire [11:0] PADDR,                    // APB byte address
    input  wire [31:0] PWDATA,                   // APB write data
    output wire [31:0] PRDATA,                   // APB read data
    output wire        PREADY,                   // APB ready
    output wire        PSLVERR,                  // APB error on unmapped address
    input  wire        WALK_SW,                  // walk inertial switch closed
    input  wire [1:0]  DIR_UP,                   // per channel, 1 east/north, 0 west/south
    input  wire [1:0]  CMP_ON,                   // per channel comparator on
    input  wire        RUN_MODE,                 // run mode selected
    input  wire        CAL_MODE,                 // calibrate mode selected
    input  wire        FAST_SLEW,                // fast slew selected
    output wire        RAMP_HOLD,                // hold ramp at start value
    output wire        CMP_CLAMP,                // clamp comparator outputs off
    output wire        LAMP_ON,                  // compass lamps energised
    output wire        COMPUTING,                // computation phase active
    output wire        RUN_TRIM_EN,              // run scale trim enabled
    output wire        DECADE_PWR,               // decade counter supply switch
    output wire [3:0]  MOTOR0,                   // channel 0 winding drives
    output wire [3:0]  MOTOR1                    // channel 1 winding drives
);

    function [2:0] sctc_ones;
        input [4:0] v;
        begin
            sctc_ones = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]} + {2'b00, v[4]};
        end
    endfunction

    // Loads and end counts cut to their counter widths; dividers must fit 16 bits
    localparam [31:0] TICK_LAST_W   = TICK_DIV - 1;
    localparam [31:0] PWR_LAST_W    = PWR_DIV - 1;
    localparam [31:0] PWR_ON_W      = PWR_ON;
    localparam [31:0] LOCK_TICKS_W  = `SCTC_LOCKOUT_TICKS;
    localparam [31:0] WARM_LAST_W   = `SCTC_WARMUP_TICKS - 1;
    localparam [31:0] MOTOR_TICKS_W = `SCTC_MOTOR_TICKS;
    localparam [15:0] TICK_LAST     = TICK_LAST_W[15:0];
    localparam [15:0] PWR_LAST      = PWR_LAST_W[15:0];
    localparam [15:0] PWR_ON_CNT    = PWR_ON_W[15:0];
    localparam [9:0]  LOCK_TICKS    = LOCK_TICKS_W[9:0];
    localparam [6:0]  WARM_LAST     = WARM_LAST_W[6:0];
    localparam [6:0]  MOTOR_TICKS   = MOTOR_TICKS_W[6:0];

    // Input synchronisers
    reg  [5:0]  sync1;
    reg  [5:0]  sync2;
    reg         walk_d;
    wire        walk_s   = sync2[0];
    wire [1:0]  dir_s    = sync2[2:1];
    wire [1:0]  cmp_s    = sync2[4:3];
    wire        run_s    = sync2[5];

    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            sync1  <= 6'h00;
            sync2  <= 6'h00;
            walk_d <= 1'b0;
        end else begin
            sync1  <= {RUN_MODE, CMP_ON, DIR_UP, WALK_SW};
            sync2  <= sync1;
            walk_d <= walk_s;
        end
    end

    // Registers
    reg         ctrl_en;
    reg         soft_clr;
    reg  [15:0] step_cnt;
    reg  [31:0] prdata;
    reg         pready;
    reg         pslverr;
    reg  [1:0]  state;
    reg  [9:0]  lock_cnt;
    reg  [6:0]  warm_cnt;
    reg         comp_armed;
    wire [9:0]  ring5_v;
    wire [7:0]  ring4_v;

    wire apb_acc = PSEL & PENABLE & ~pready;
    wire apb_wr  = apb_acc & PWRITE;

    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_en  <= `SCTC_CTRL_RESET;
            soft_clr <= 1'b0;
            prdata   <= 32'h00000000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end else begin
            pready   <= apb_acc;
            soft_clr <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h00000000;
            if (apb_acc) begin
                case (PADDR)
                    `SCTC_ADDR_CTRL: begin
                        prdata <= {31'h00000000, ctrl_en};
                        if (apb_wr) begin
                            ctrl_en  <= PWDATA[`SCTC_CTRL_EN_BIT];
                            soft_clr <= PWDATA[`SCTC_CTRL_CLR_BIT];
                        end
                    end
                    `SCTC_ADDR_STATUS:
                        prdata <= {23'h000000, run_s, cmp_s, dir_s, comp_armed, (lock_cnt != 10'h000), state};
                    `SCTC_ADDR_RINGS:
                        prdata <= {4'h0, ring4_v[7:4], 3'h0, ring5_v[9:5], 4'h0, ring4_v[3:0], 3'h0, ring5_v[4:0]};
                    `SCTC_ADDR_STEPS:
                        prdata <= {16'h0000, step_cnt};
                    default:
                        pslverr <= 1'b1;
                endcase
            end
        end
    end

    // 2.5 kc tick and 5 kc decade supply strobe
    reg  [15:0] tick_div;
    reg         tick;
    reg  [15:0] pwr_div;
    reg         decade_pwr;

    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            tick_div   <= 16'h0000;
            tick       <= 1'b0;
            pwr_div    <= 16'h0000;
            decade_pwr <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (tick_div == TICK_LAST) begin
                tick_div <= 16'h0000;
                tick     <= 1'b1;
            end else begin
                tick_div <= tick_div + 16'h0001;
            end
            if (pwr_div == PWR_LAST)
                pwr_div <= 16'h0000;
            else
                pwr_div <= pwr_div + 16'h0001;
            decade_pwr <= (pwr_div < PWR_ON_CNT);
        end
    end

    // Cycle control
    wire start = walk_s & ~walk_d & ctrl_en & (lock_cnt == 10'h000) & (state == `SCTC_ST_IDLE);
    reg  [1:0]  next_state;

    always @* begin
        next_state = state;
        case (state)
            `SCTC_ST_IDLE:
                if (start)
                    next_state = `SCTC_ST_WARM;
            `SCTC_ST_WARM:
                if (tick && warm_cnt == WARM_LAST)
                    next_state = `SCTC_ST_COMP;
            `SCTC_ST_COMP:
                // Comparators need a tick after release to come on; checking earlier ends at once
                if (comp_armed && cmp_s == 2'b00)
                    next_state = `SCTC_ST_IDLE;
            default:
                next_state = `SCTC_ST_IDLE;
        endcase
        if (soft_clr)
            next_state = `SCTC_ST_IDLE;
    end

    reg ramp_hold;
    reg cmp_clamp;
    reg lamp_on;
    reg computing;
    reg run_trim_en;

    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state       <= `SCTC_ST_IDLE;
            lock_cnt    <= 10'h000;
            warm_cnt    <= 7'h00;
            comp_armed  <= 1'b0;
            ramp_hold   <= 1'b1;
            cmp_clamp   <= 1'b1;
            lamp_on     <= 1'b0;
            computing   <= 1'b0;
            run_trim_en <= 1'b0;
        end else begin
            state <= next_state;
            if (soft_clr) begin
                lock_cnt <= 10'h000;
            end else if (start) begin
                lock_cnt <= LOCK_TICKS;
            end else if (tick && lock_cnt != 10'h000) begin
                lock_cnt <= lock_cnt - 10'h001;
            end
            if (state != `SCTC_ST_WARM || soft_clr)
                warm_cnt <= 7'h00;
            else if (tick)
                warm_cnt <= warm_cnt + 7'h01;
            if (state != `SCTC_ST_COMP || soft_clr)
                comp_armed <= 1'b0;
            else if (tick)
                comp_armed <= 1'b1;
            ramp_hold   <= (next_state != `SCTC_ST_COMP);
            cmp_clamp   <= (next_state != `SCTC_ST_COMP);
            lamp_on     <= (next_state != `SCTC_ST_IDLE);
            computing   <= (next_state == `SCTC_ST_COMP);
            run_trim_en <= run_s;
        end
    end

    // Mode select: one decade bypassed for calibrate and fast slew
    reg fast_mode;

    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN)
            fast_mode <= 1'b0;
        else
            fast_mode <= CAL_MODE | FAST_SLEW;
    end

    // Counting channels
    // Each channel owns its registers and shows them on flat buses, one driver per bit
    wire [7:0] motor_v;
    wire [1:0] step_evt;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            reg  [3:0] dec_lo;
            reg  [3:0] dec_hi;
            reg  [4:0] ring5;
            reg  [3:0] ring4;
            reg  [6:0] mot_cnt;
            reg  [3:0] motor;
            reg        step_q;
            // Off comparators and the clamp both stop pulses from entering the chain
            wire       gated   = tick & (state == `SCTC_ST_COMP) & cmp_s[ch];
            wire       lo_wrap = gated & (dec_lo == `SCTC_DECADE_LAST);
            wire       hi_wrap = lo_wrap & (dec_hi == `SCTC_DECADE_LAST);
            wire       div_out = fast_mode ? lo_wrap : hi_wrap;
            wire [4:0] r5_next = dir_s[ch] ? {ring5[3:0], ring5[4]}
                                           : {ring5[0], ring5[4:1]};
            wire [3:0] r4_next = dir_s[ch] ? {ring4[2:0], ring4[3]}
                                           : {ring4[0], ring4[3:1]};
            wire       r5_bad  = sctc_ones(ring5) != 3'd1;
            wire       r4_bad  = sctc_ones({1'b0, ring4}) != 3'd1;
            wire       advance = div_out & ~r5_bad & (r5_next == `SCTC_RING5_HOME);

            always @(posedge MCLK or negedge RESETN) begin
                if (!RESETN) begin
                    dec_lo  <= 4'h0;
                    dec_hi  <= 4'h0;
                    ring5   <= `SCTC_RING5_HOME;
                    ring4   <= `SCTC_RING4_HOME;
                    mot_cnt <= 7'h00;
                    motor   <= 4'h0;
                    step_q  <= 1'b0;
                end else if (soft_clr) begin
                    dec_lo  <= 4'h0;
                    dec_hi  <= 4'h0;
                    ring5   <= `SCTC_RING5_HOME;
                    ring4   <= `SCTC_RING4_HOME;
                    mot_cnt <= 7'h00;
                    motor   <= 4'h0;
                    step_q  <= 1'b0;
                end else begin
                    step_q <= 1'b0;
                    if (gated)
                        dec_lo <= lo_wrap ? 4'h0 : dec_lo + 4'h1;
                    if (lo_wrap && !fast_mode)
                        dec_hi <= hi_wrap ? 4'h0 : dec_hi + 4'h1;
                    if (r5_bad)
                        ring5 <= `SCTC_RING5_HOME;
                    else if (div_out)
                        ring5 <= r5_next;
                    if (r4_bad) begin
                        ring4 <= `SCTC_RING4_HOME;
                    end else if (advance) begin
                        ring4  <= r4_next;
                        step_q <= 1'b1;
                    end
                    // Each ring4 advance restarts a timed pulse on the full new winding
                    if (advance && !r4_bad) begin
                        motor   <= r4_next;
                        mot_cnt <= MOTOR_TICKS;
                    end else if (tick && mot_cnt != 7'h00) begin
                        mot_cnt <= mot_cnt - 7'h01;
                        if (mot_cnt == 7'h01)
                            motor <= 4'h0;
                    end
                end
            end

            assign ring5_v[5*ch +: 5] = ring5;
            assign ring4_v[4*ch +: 4] = ring4;
            assign motor_v[4*ch +: 4] = motor;
            assign step_evt[ch]       = step_q;
        end
    endgenerate

    // Stepping rate is bounded by the tick: at least 50 ticks between advances, or 20 when the direction reverses
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN)
            step_cnt <= 16'h0000;
        else if (soft_clr)
            step_cnt <= 16'h0000;
        else
            step_cnt <= step_cnt + {15'h0000, step_evt[0]} + {15'h0000, step_evt[1]};
    end

    assign PRDATA      = prdata;
    assign PREADY      = pready;
    assign PSLVERR     = pslverr;
    assign RAMP_HOLD   = ramp_hold;
    assign CMP_CLAMP   = cmp_clamp;
    assign LAMP_ON     = lamp_on;
    assign COMPUTING   = computing;
    assign RUN_TRIM_EN = run_trim_en;
    assign DECADE_PWR  = decade_pwr;
    assign MOTOR0      = motor_v[3:0];
    assign MOTOR1      = motor_v[7:4];

endmodule // sctc_top

// >>> bench/sctc_chk.sv
// Checker: port timing relations of the step cycle travel counter.
// Assumes a bind onto sctc_top run with small tick and supply dividers.
`timescale 1ns/1ns
module sctc_chk #(
    parameter TICK_DIV = 8, // MCLK cycles per tick
    parameter PWR_ON   = 2  // supply on cycles
) (
    input wire       MCLK,        // clock
    input wire       RESETN,      // reset, low
    input wire       PSEL,        // select
    input wire       PENABLE,     // access
    input wire       PREADY,      // ready
    input wire       WALK_SW,     // switch
    input wire [1:0] CMP_ON,      // comparators
    input wire       RUN_MODE,    // run mode
    input wire       RAMP_HOLD,   // ramp hold
    input wire       CMP_CLAMP,   // clamp
    input wire       LAMP_ON,     // lamps
    input wire       COMPUTING,   // computing
    input wire       RUN_TRIM_EN, // trim
    input wire       DECADE_PWR,  // supply
    input wire [3:0] MOTOR0       // drive
);
    localparam int END_LIM = 24;
    reg [15:0] warm_n;
    reg [15:0] mot_n;
    reg [7:0]  hi_n;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    // Run lengths, so long intervals are judged by a counter, not by repetition
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            warm_n <= 16'h0000;
            mot_n  <= 16'h0000;
            hi_n   <= 8'h00;
        end else begin
            warm_n <= (LAMP_ON && !COMPUTING) ? warm_n + 16'h0001 : 16'h0000;
            mot_n  <= (MOTOR0 != 4'h0) ? mot_n + 16'h0001 : 16'h0000;
            hi_n   <= DECADE_PWR ? hi_n + 8'h01 : 8'h00;
        end
    end
    sequence s_access; PSEL && PENABLE && !PREADY; endsequence
    sequence s_both_off; (COMPUTING && CMP_ON == 2'b00) [*2]; endsequence
    sequence s_motor_on; (MOTOR0 != 4'h0) ##1 (MOTOR0 != 4'h0); endsequence
    property p_apb_wait; s_access |=> PREADY; endproperty
    property p_start; $rose(LAMP_ON) |-> RAMP_HOLD && ($past(WALK_SW, 3) || $past(WALK_SW, 5)); endproperty
    property p_warm; $rose(COMPUTING) |-> warm_n >= 62 * TICK_DIV && warm_n <= 75 * TICK_DIV + 2; endproperty
    property p_clamp; CMP_CLAMP == !COMPUTING && RAMP_HOLD == !COMPUTING; endproperty
    property p_end; s_both_off |-> ##[0:END_LIM] !COMPUTING; endproperty
    property p_motor_hot; MOTOR0 == 4'h0 || $onehot(MOTOR0); endproperty
    property p_motor_hold; s_motor_on |-> MOTOR0 == $past(MOTOR0); endproperty
    property p_motor_len; $fell(MOTOR0 != 4'h0) |-> mot_n >= 99 * TICK_DIV && mot_n <= 100 * TICK_DIV + 1; endproperty
    property p_pwr; $fell(DECADE_PWR) |-> hi_n == PWR_ON; endproperty
    property p_trim; (!RUN_MODE) [*4] |-> !RUN_TRIM_EN; endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("ready late");
    a_start: assert property (p_start) else $error("start without switch");
    a_warm: assert property (p_warm) else $error("warm-up length wrong");
    a_clamp: assert property (p_clamp) else $error("clamp or hold wrong");
    a_end: assert property (p_end) else $error("cycle did not end");
    a_motor_hot: assert property (p_motor_hot) else $error("drive not one-hot");
    a_motor_hold: assert property (p_motor_hold) else $error("drive changed");
    a_motor_len: assert property (p_motor_len) else $error("drive pulse length");
    a_pwr: assert property (p_pwr) else $error("supply duty wrong");
    a_trim: assert property (p_trim) else $error("trim on without run");
endmodule // sctc_chk

// >>> bench/sctc_far.sv
// Far side: two ramp comparators and the compass quadrant sensors.
// Assumes the ramp sweeps only while released and crosses each level after a set tick count.
`timescale 1ns/1ns
module sctc_far #(
    parameter TICK_DIV = 8 // MCLK cycles per tick
) (
    input  wire        MCLK,      // clock
    input  wire        RESETN,    // reset, low
    input  wire        RAMP_HOLD, // ramp held
    input  wire        CMP_CLAMP, // forced off
    input  wire [15:0] len0,      // ticks to crossing, ch 0
    input  wire [15:0] len1,      // ticks to crossing, ch 1
    input  wire [1:0]  dir,       // heading, 1 east/north
    output wire [1:0]  DIR_UP,    // quadrant outputs
    output wire [1:0]  CMP_ON     // comparator outputs
);
    reg [23:0] ramp;
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ramp <= 24'h000000;
        end else if (RAMP_HOLD) begin
            ramp <= 24'h000000;
        end else begin
            ramp <= ramp + 24'h000001;
        end
    end
    // Drops at the crossing itself, well inside one pulse width
    assign CMP_ON[0] = !CMP_CLAMP && (ramp < len0 * TICK_DIV);
    assign CMP_ON[1] = !CMP_CLAMP && (ramp < len1 * TICK_DIV);
    assign DIR_UP = dir;
endmodule // sctc_far

// >>> bench/sctc_top_bench.sv
// Bench for sctc_top: cycles in each mode through the far-side model, pins and registers.
// Assumes small dividers so that whole steps fit a short run.
`timescale 1ns/1ns
module sctc_top_bench;
    localparam TICK_DIV = 8;
    reg MCLK = 1'b0, RESETN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, WALK_SW = 1'b0;
    reg RUN_MODE = 1'b0, CAL_MODE = 1'b0, FAST_SLEW = 1'b0, rd_err;
    reg [11:0] PADDR = 12'h000;
    reg [31:0] PWDATA = 32'h0, rd_data;
    reg [15:0] len0 = 16'h0000, len1 = 16'h0000;
    reg [1:0]  dir = 2'b00;
    reg [3:0]  seen0, seen1;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, RAMP_HOLD, CMP_CLAMP, LAMP_ON, COMPUTING, RUN_TRIM_EN, DECADE_PWR;
    wire [1:0] DIR_UP, CMP_ON;
    wire [3:0] MOTOR0, MOTOR1;
    integer err_count = 0, n_checks = 0, cyc = 0;
    sctc_top #(.TICK_DIV(TICK_DIV), .PWR_DIV(8), .PWR_ON(2)) DUT (.MCLK(MCLK), .RESETN(RESETN),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .WALK_SW(WALK_SW), .DIR_UP(DIR_UP), .CMP_ON(CMP_ON),
        .RUN_MODE(RUN_MODE), .CAL_MODE(CAL_MODE), .FAST_SLEW(FAST_SLEW), .RAMP_HOLD(RAMP_HOLD),
        .CMP_CLAMP(CMP_CLAMP), .LAMP_ON(LAMP_ON), .COMPUTING(COMPUTING), .RUN_TRIM_EN(RUN_TRIM_EN),
        .DECADE_PWR(DECADE_PWR), .MOTOR0(MOTOR0), .MOTOR1(MOTOR1));
    sctc_far #(.TICK_DIV(TICK_DIV)) u_far (.MCLK(MCLK), .RESETN(RESETN), .RAMP_HOLD(RAMP_HOLD),
        .CMP_CLAMP(CMP_CLAMP), .len0(len0), .len1(len1), .dir(dir), .DIR_UP(DIR_UP), .CMP_ON(CMP_ON));
    always #5 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        cyc = cyc + 1;
        if (MOTOR0 != 4'h0) seen0 = MOTOR0;
        if (MOTOR1 != 4'h0) seen1 = MOTOR1;
        if (cyc == 30000) begin
            err_count = err_count + 1;
            test_done;
        end
    end
    task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        @(posedge MCLK);
        while (PREADY !== 1'b1) @(posedge MCLK);
        rd_data = PRDATA;
        rd_err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task press;
        @(posedge MCLK);
        WALK_SW <= 1'b1;
        repeat (20) @(posedge MCLK);
        WALK_SW <= 1'b0;
        repeat (10) @(posedge MCLK);
    endtask
    task t_reset;
        chk("clamps", {RAMP_HOLD, CMP_CLAMP, LAMP_ON, COMPUTING}, 32'hc);
        chk("motors", {MOTOR1, MOTOR0}, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", rd_data, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk("rings", rd_data, 32'h0101_0101);
        apb(1'b1, 12'h010, 32'hffff_ffff);
        chk("unmapped", rd_err, 32'h1);
        $display("test reset done");
    endtask
    task t_ctrl;
        apb(1'b1, 12'h000, 32'h0);
        press;
        chk("disabled", LAMP_ON, 32'h0);
        RUN_MODE <= 1'b1;
        repeat (5) @(posedge MCLK);
        chk("trim on", RUN_TRIM_EN, 32'h1);
        RUN_MODE <= 1'b0;
        repeat (5) @(posedge MCLK);
        chk("trim off", RUN_TRIM_EN, 32'h0);
        $display("test ctrl done");
    endtask
    // Crossing counts sit at least 3 ticks clear of ring moves, so tick phase cannot change the result
    task t_step(input [1:0] mode, input [1:0] d, input [15:0] l0, input [15:0] l1, input [31:0] rings,
                input [7:0] mot);
        apb(1'b1, 12'h000, 32'h3);
        CAL_MODE <= mode[0];
        FAST_SLEW <= mode[1];
        RUN_MODE <= mode == 2'b00;
        dir <= d;
        len0 <= l0;
        len1 <= l1;
        seen0 = 4'h0;
        seen1 = 4'h0;
        repeat (4) @(posedge MCLK);
        press;
        chk("warm", {LAMP_ON, COMPUTING}, 32'h2);
        wait (COMPUTING === 1'b1);
        wait (COMPUTING === 1'b0);
        press;
        chk("lockout", LAMP_ON, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk("status", rd_data[2:0], 32'h4);
        repeat (900) @(posedge MCLK);
        chk("drive", {seen1, seen0}, mot);
        apb(1'b0, 12'h008, 32'h0);
        chk("rings", rd_data, rings);
        apb(1'b0, 12'h00c, 32'h0);
        chk("steps", rd_data, 32'h1);
        $display("test step mode %0d done", mode);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge MCLK);
        RESETN <= 1'b1;
        t_reset;
        t_ctrl;
        t_step(2'b00, 2'b01, 16'h0208, 16'h00fa, 32'h0108_0201, 8'h02);
        t_step(2'b01, 2'b10, 16'h0037, 16'h0023, 32'h0108_0801, 8'h08);
        t_step(2'b10, 2'b11, 16'h0019, 16'h0039, 32'h0201_0104, 8'h20);
        test_done;
    end
endmodule // sctc_top_bench
bind sctc_top sctc_chk #(.TICK_DIV(TICK_DIV), .PWR_ON(PWR_ON)) u_chk (.MCLK(MCLK), .RESETN(RESETN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .WALK_SW(WALK_SW), .CMP_ON(CMP_ON),
    .RUN_MODE(RUN_MODE), .RAMP_HOLD(RAMP_HOLD), .CMP_CLAMP(CMP_CLAMP), .LAMP_ON(LAMP_ON),
    .COMPUTING(COMPUTING), .RUN_TRIM_EN(RUN_TRIM_EN), .DECADE_PWR(DECADE_PWR), .MOTOR0(MOTOR0));
